// [design/eeprom_pkg.sv]
// Constants, field layout and state codes of the serial data EEPROM.
// Assumes a 200 MHz system clock and an 8-bit control byte on the link.
package eeprom_pkg;

    // Memory shape: rows of one word each.
    localparam int ROW_W  = 5;
    localparam int WORD_W = 16;
    localparam int ROWS   = 32;

    // Control byte fields, counted from the least significant bit.
    localparam int DIR_BIT     = 0;
    localparam int MODE_LO_BIT = 1;
    localparam int MODE_HI_BIT = 2;
    localparam int ROW_LSB     = 3;

    // The initialization byte that only asks for an acknowledge.
    localparam logic [7:0] INIT_BYTE = 8'hFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] ROW_ONE   = 5'h01;

    // Erase plus write cycle time and the cycle count derived from it.
    localparam int T_PROG_US   = 10000;
    localparam int CLK_MHZ     = 200;
    localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;

    // Write queue depth between the link and the programming engine.
    localparam int FIFO_DEPTH = 8;

    // Link-side protocol states, one-hot.
    typedef enum logic [6:0] {
        L_IDLE  = 7'h01,
        L_CTRL  = 7'h02,
        L_ACK   = 7'h04,
        L_WDATA = 7'h08,
        L_TX    = 7'h10,
        L_MACK  = 7'h20,
        L_IGN   = 7'h40
    } link_state_t;

endpackage

// [design/word_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  logic             clk_sys,
    input  logic             rst_n,
    // Filling side
    input  logic             in_valid,
    input  logic [WIDTH-1:0] in_data,
    output logic             in_ready,
    // Draining side
    output logic             out_valid,
    output logic [WIDTH-1:0] out_data,
    input  logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    // Pointers only wrap cleanly on a power-of-two depth.
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("word_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // The extra pointer bit tells full from empty.
    assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage carries no reset; only the pointers define content.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule

// [design/eeprom_serial_word_access.sv]
// Data EEPROM slave behind a two-wire serial link, with a word buffer.
// Assumes clk_link runs at least ten times faster than SCL toggles and
// that the on-chip master drives SCL; SDA is open drain with a pull-up.
// Function
// - Write control byte with modes 0,1 takes the low byte first.
// - Write control byte with modes 0,0 takes the high byte first.
// - A read control byte is acknowledged, its row buffered, sent.
// - After both buffered bytes the row steps and reloads.
// - The low mode bit picks both first byte and row step direction.
// - Read modes 0,1 give low first upward; 1,0 high first downward.
// - The row address wraps at either end and reading continues.
// - The device acknowledges FFh once idle; the master may retry.
// - Control byte: 5-bit row, two mode bits, then direction bit.
// - 32 rows of 16 bits; each access loads the whole row first.
// - No control byte is acknowledged during the 10 ms program.
// - Start and stop are SDA edges while SCL is high.
`timescale 1ns/1ps
module eeprom_serial_word_access #(
    parameter int FIFO_DEPTH  = eeprom_pkg::FIFO_DEPTH,
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    // System clock domain
    input  logic clk_sys,
    input  logic rst_n,
    // Serial link, sampled on the link clock
    input  logic clk_link,
    input  logic scl,
    input  logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Status
    output logic prog_busy
);
    localparam int ROW_W  = eeprom_pkg::ROW_W;
    localparam int WORD_W = eeprom_pkg::WORD_W;
    localparam int REQ_W  = ROW_W + WORD_W;
    localparam int CNT_W  = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYCLES);

    if (PROG_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_chk
        $error("eeprom: PROG_CYCLES and FIFO_DEPTH too small");
    end

    // True when the upper byte is the one at the current buffer half.
    function automatic logic sel_upper(input logic low_first,
                                       input logic half);
        sel_upper = (low_first == half);
    endfunction

    // Link domain registers.
    logic [1:0]              rst_meta;
    logic                    link_rst_n;
    logic [1:0]              pin_m;
    logic [1:0]              pin_s;
    logic [1:0]              pin_d;
    logic                    busy_m;
    logic                    busy_s;
    logic                    ack_m;
    logic                    ack_s;
    logic                    ack_d;
    eeprom_pkg::link_state_t state;
    eeprom_pkg::link_state_t after_ack;
    logic [7:0]              sr;
    logic [3:0]              bitcnt;
    logic [1:0]              nbytes;
    logic                    first_low;
    logic                    dir_up;
    logic                    half;
    logic                    wr_session;
    logic [WORD_W-1:0]       row_buf;
    logic                    req_tgl;
    logic                    req_write;
    logic [ROW_W-1:0]        req_row;
    logic [WORD_W-1:0]       req_data;

    // System domain registers.
    logic                    req_m;
    logic                    req_s;
    logic                    req_d;
    logic                    pending;
    logic                    ack_tgl;
    logic [WORD_W-1:0]       rd_word;
    logic [WORD_W-1:0]       mem [eeprom_pkg::ROWS];
    logic [CNT_W-1:0]        prog_cnt;

    // Link decode.
    logic              scl_s;
    logic              scl_d;
    logic              sda_s;
    logic              sda_d;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_det;
    logic              stop_det;
    logic              byte_end;
    logic              link_busy;
    logic              load_done;
    logic              ctrl_take;
    logic              ctrl_init;
    logic              step_req;
    logic              write_req;
    logic              data_take;
    logic [7:0]        tx_byte;
    logic [ROW_W-1:0]  next_row;

    // FIFO and engine wires.
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [REQ_W-1:0]  fifo_out_data;
    logic              pop;

    // Reset reaches the link domain through two flops of its own.
    always_ff @(posedge clk_link) begin
        rst_meta <= {rst_meta[0], rst_n};
    end
    assign link_rst_n = rst_meta[1];

    // Pins and status from the system side pass two flops first.
    always_ff @(posedge clk_link) begin
        pin_m  <= {scl, sda_i};
        pin_s  <= pin_m;
        pin_d  <= pin_s;
        busy_m <= prog_busy;
        busy_s <= busy_m;
        ack_m  <= ack_tgl;
        ack_s  <= ack_m;
        ack_d  <= ack_s;
    end

    assign scl_s    = pin_s[1];
    assign sda_s    = pin_s[0];
    assign scl_d    = pin_d[1];
    assign sda_d    = pin_d[0];
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;

    // SDA moving while SCL stays high marks the frame edges.
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // An unanswered request counts as busy so no gap opens.
    assign link_busy = busy_s | (req_tgl != ack_s);
    assign load_done = ack_s != ack_d;
    assign byte_end  = scl_fall & (bitcnt == eeprom_pkg::BYTE_BITS);

    // Control byte decode at the falling edge closing bit eight.
    assign ctrl_take = (state == eeprom_pkg::L_CTRL) & byte_end
                       & ~link_busy;
    assign ctrl_init = sr == eeprom_pkg::INIT_BYTE;
    assign data_take = (state == eeprom_pkg::L_WDATA) & byte_end;

    // Master acknowledged the second byte of the word.
    assign step_req  = (state == eeprom_pkg::L_MACK) & scl_rise
                       & ~sda_s & half;
    assign write_req = stop_det & wr_session & (nbytes != 2'h0);

    // Five-bit arithmetic wraps past either end on its own.
    assign next_row = dir_up ? req_row + eeprom_pkg::ROW_ONE
                             : req_row - eeprom_pkg::ROW_ONE;

    assign tx_byte = sel_upper(first_low, half)
                     ? row_buf[15:8] : row_buf[7:0];

    // Protocol state machine; bits are taken on SCL rising edges and
    // driven after SCL falling edges so SDA only moves while SCL is low.
    always_ff @(posedge clk_link) begin
        if (!link_rst_n) begin
            state      <= eeprom_pkg::L_IDLE;
            after_ack  <= eeprom_pkg::L_IDLE;
            sr         <= 8'h00;
            bitcnt     <= 4'h0;
            nbytes     <= 2'h0;
            first_low  <= 1'b0;
            dir_up     <= 1'b0;
            half       <= 1'b0;
            wr_session <= 1'b0;
            sda_oe     <= 1'b0;
            sda_o      <= 1'b0;
        end else if (start_det) begin
            state      <= eeprom_pkg::L_CTRL;
            bitcnt     <= 4'h0;
            nbytes     <= 2'h0;
            wr_session <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (stop_det) begin
            state      <= eeprom_pkg::L_IDLE;
            wr_session <= 1'b0;
            sda_oe     <= 1'b0;
        end else begin
            case (state)
                eeprom_pkg::L_CTRL, eeprom_pkg::L_WDATA: begin
                    if (scl_rise) begin
                        sr     <= {sr[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (ctrl_take) begin
                        // Field split of the control byte.
                        first_low <= sr[eeprom_pkg::MODE_LO_BIT];
                        dir_up    <= sr[eeprom_pkg::MODE_LO_BIT];
                        half      <= 1'b0;
                        sda_oe    <= 1'b1;
                        state     <= eeprom_pkg::L_ACK;
                        if (ctrl_init) begin
                            after_ack <= eeprom_pkg::L_IGN;
                        end else if (sr[eeprom_pkg::DIR_BIT]) begin
                            after_ack <= eeprom_pkg::L_TX;
                        end else begin
                            after_ack  <= eeprom_pkg::L_WDATA;
                            wr_session <= 1'b1;
                        end
                    end else if (data_take) begin
                        // Two bytes at most; a third goes unanswered.
                        nbytes    <= nbytes + 2'h1;
                        half      <= ~half;
                        sda_oe    <= 1'b1;
                        state     <= eeprom_pkg::L_ACK;
                        after_ack <= (nbytes == 2'h1) ? eeprom_pkg::L_IGN
                                                      : eeprom_pkg::L_WDATA;
                    end else if (byte_end) begin
                        state <= eeprom_pkg::L_IGN;
                    end
                end
                eeprom_pkg::L_ACK: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        state  <= after_ack;
                        if (after_ack == eeprom_pkg::L_TX) begin
                            sda_oe <= ~tx_byte[7];
                            sr     <= {tx_byte[6:0], 1'b0};
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                end
                eeprom_pkg::L_TX: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                    end else if (byte_end) begin
                        sda_oe <= 1'b0;
                        state  <= eeprom_pkg::L_MACK;
                    end else if (scl_fall) begin
                        sda_oe <= ~sr[7];
                        sr     <= {sr[6:0], 1'b0};
                    end
                end
                eeprom_pkg::L_MACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            half      <= ~half;
                            after_ack <= eeprom_pkg::L_TX;
                            state     <= eeprom_pkg::L_ACK;
                        end else begin
                            state <= eeprom_pkg::L_IGN;
                        end
                    end
                end
                eeprom_pkg::L_IDLE, eeprom_pkg::L_IGN: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    state  <= eeprom_pkg::L_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Requests to the memory side; fields stay put until acknowledged.
    always_ff @(posedge clk_link) begin
        if (!link_rst_n) begin
            req_tgl   <= 1'b0;
            req_write <= 1'b0;
            req_row   <= '0;
            req_data  <= '0;
        end else if (ctrl_take && !ctrl_init) begin
            req_tgl   <= ~req_tgl;
            req_write <= 1'b0;
            req_row   <= sr[eeprom_pkg::ROW_LSB +: ROW_W];
        end else if (step_req) begin
            req_tgl   <= ~req_tgl;
            req_write <= 1'b0;
            req_row   <= next_row;
        end else if (write_req) begin
            req_tgl   <= ~req_tgl;
            req_write <= 1'b1;
            req_data  <= row_buf;
        end
    end

    // Row buffer: whole-row load, then byte overwrite in chosen order.
    always_ff @(posedge clk_link) begin
        if (!link_rst_n) begin
            row_buf <= '0;
        end else if (load_done && !req_write) begin
            row_buf <= rd_word;
        end else if (data_take) begin
            if (sel_upper(first_low, half)) begin
                row_buf[15:8] <= sr;
            end else begin
                row_buf[7:0] <= sr;
            end
        end
    end

    // Request toggle reaches the system clock through two flops.
    always_ff @(posedge clk_sys) begin
        req_m <= req_tgl;
        req_s <= req_m;
        req_d <= req_s;
    end

    // Serve one request: reads answer at once, writes wait for space.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pending <= 1'b0;
            ack_tgl <= 1'b0;
            rd_word <= '0;
        end else if (req_s != req_d) begin
            pending <= 1'b1;
        end else if (pending && (!req_write || fifo_in_ready)) begin
            pending <= 1'b0;
            ack_tgl <= ~ack_tgl;
            if (!req_write) begin
                rd_word <= mem[req_row];
            end
        end
    end

    assign fifo_in_valid = pending & req_write;

    // Words waiting for programming; a full queue holds the answer back.
    word_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_data   ({req_row, req_data}),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (prog_cnt == '0)
    );

    assign pop = fifo_out_valid & (prog_cnt == '0);

    // The array itself; content survives reset as an EEPROM would.
    always_ff @(posedge clk_sys) begin
        if (pop) begin
            mem[fifo_out_data[WORD_W +: ROW_W]] <= fifo_out_data[WORD_W-1:0];
        end
    end

    // Programming timer holds the engine for the erase plus write time.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prog_cnt <= '0;
        end else if (pop) begin
            prog_cnt <= PROG_LOAD;
        end else if (prog_cnt != '0) begin
            prog_cnt <= prog_cnt - 1'b1;
        end
    end

    // Busy covers queued, pending and programming work alike.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prog_busy <= 1'b0;
        end else begin
            prog_busy <= fifo_in_valid | fifo_out_valid
                         | (prog_cnt > CNT_W'(1));
        end
    end

endmodule

// [dv/eeprom_serial_word_access_sva.sv]
// Concurrent checks on the serial memory link pins and the busy flag.
// Assumes SCL comes from the master and SDA is resolved with a pull-up.
`timescale 1ns/1ps
module eeprom_link_checker #(
    parameter int PROG_CYCLES = 200
) (
    // System clock domain
    input logic clk_sys,
    input logic rst_n,
    // Link
    input logic clk_link,
    input logic scl,
    input logic sda_i,
    input logic sda_o,
    input logic sda_oe,
    // Status
    input logic prog_busy
);
    localparam int BUSY_MAX = PROG_CYCLES + 1000;
    logic [3:0] low_cnt;
    int         busy_cnt;

    // Link cycles since SCL fell; saturates so a long low phase is legal.
    always_ff @(posedge clk_link) begin
        if (!rst_n || scl) begin
            low_cnt <= 4'h0;
        end else if (low_cnt != 4'hF) begin
            low_cnt <= low_cnt + 4'h1;
        end
    end

    // Length of the current busy stretch in system cycles.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !prog_busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    sequence s_start;
        scl && $past(scl) && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda_i);
    endsequence

    property p_od;
        @(posedge clk_link) disable iff (!rst_n) !sda_o;
    endproperty
    property p_oe_rise_low;
        @(posedge clk_link) disable iff (!rst_n)
            $rose(sda_oe) |-> !scl && !$past(scl);
    endproperty
    property p_oe_hold_high;
        @(posedge clk_link) disable iff (!rst_n)
            scl && $past(scl) |-> $stable(sda_oe);
    endproperty
    property p_oe_timing;
        @(posedge clk_link) disable iff (!rst_n)
            $changed(sda_oe) |-> !scl && low_cnt inside {[1:9]};
    endproperty
    property p_start_free;
        @(posedge clk_link) disable iff (!rst_n) s_start |-> !sda_oe;
    endproperty
    property p_stop_idle;
        @(posedge clk_link) disable iff (!rst_n) s_stop |=> !sda_oe [*8];
    endproperty
    property p_busy_min;
        @(posedge clk_sys) disable iff (!rst_n)
            $fell(prog_busy) |-> busy_cnt >= PROG_CYCLES;
    endproperty
    property p_busy_max;
        @(posedge clk_sys) disable iff (!rst_n) busy_cnt < BUSY_MAX;
    endproperty

    a_od: assert property (p_od)
        else $error("device drives SDA high");
    a_oe_rise_low: assert property (p_oe_rise_low)
        else $error("device pulls SDA while SCL high");
    a_oe_hold_high: assert property (p_oe_hold_high)
        else $error("SDA drive changed during SCL high");
    a_oe_timing: assert property (p_oe_timing)
        else $error("SDA drive changed out of the low-phase slot");
    a_start_free: assert property (p_start_free)
        else $error("device drives SDA at a start");
    a_stop_idle: assert property (p_stop_idle)
        else $error("device drives SDA after a stop");
    a_busy_min: assert property (p_busy_min)
        else $error("programming ended too early");
    a_busy_max: assert property (p_busy_max)
        else $error("programming lasts too long");
endmodule

bind eeprom_serial_word_access eeprom_link_checker #(
    .PROG_CYCLES(PROG_CYCLES)
) chk_i (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_link (clk_link),
    .scl      (scl),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .prog_busy(prog_busy)
);

// [dv/link_master.sv]
// Behavioural bus master of the two-wire memory link.
// Assumes the bench resolves SDA from sda_m, the device and a pull-up.
`timescale 1ns/1ps
module link_master #(
    parameter int HALF_NS = 600
) (
    // Link pins
    output logic scl,
    output logic sda_m,
    input  wire  sda
);
    // SCL stands high and SDA is released outside frames.
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    // Start: SDA falls while SCL is high.
    task automatic start();
        sda_m = 1'b1;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS / 2);
        sda_m = 1'b0;
        #(HALF_NS / 2);
        scl = 1'b0;
        #(HALF_NS / 2);
    endtask

    // Stop: SDA rises while SCL is high.
    task automatic stop();
        sda_m = 1'b0;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS / 2);
        sda_m = 1'b1;
        #HALF_NS;
    endtask

    // One clock; data changes only in the low phase, sampled when high.
    task automatic clock_bit(input logic b, output logic s);
        sda_m = b;
        #(HALF_NS / 2);
        scl = 1'b1;
        #(HALF_NS / 2);
        s = sda;
        #(HALF_NS / 2);
        scl = 1'b0;
        #(HALF_NS / 2);
    endtask

    // Byte out, most significant bit first; ack is the ninth bit.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, ack);
    endtask

    // Byte in; the master acks only when it wants more.
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(!more, s);
    endtask

    // Initialization frame, sent a second time if left unanswered.
    task automatic init_link(output logic ack);
        for (int t = 0; t < 2; t++) begin
            start();
            send_byte(eeprom_pkg::INIT_BYTE, ack);
            stop();
            if (ack === 1'b0) break;
        end
    endtask
endmodule

// [dv/tb.sv]
// Self-checking bench of the serial word EEPROM.
// Assumes the link master model and the bound checker are compiled.
`timescale 1ns/1ps
module tb;
    // Long enough that a poll after a write still meets a busy device.
    localparam int PROG = 3000;
    typedef struct packed {
        logic [4:0]  row;
        logic        lo;
        logic        two;
        logic [15:0] data;
    } case_t;
    logic        clk_sys;
    logic        clk_link;
    logic        rst_n;
    logic        scl;
    logic        sda_m;
    logic        sda_o;
    logic        sda_oe;
    logic        prog_busy;
    logic        a;
    wire         sda_w;
    logic [15:0] mem [32];
    int          failures;
    int          comparisons;
    // Row, low-first, two bytes, word; the last two change one half.
    case_t       rows [4] = '{
        '{5'h00, 1'b1, 1'b1, 16'h1234},
        '{5'h1F, 1'b0, 1'b1, 16'hA55A},
        '{5'h00, 1'b1, 1'b0, 16'h0077},
        '{5'h1F, 1'b0, 1'b0, 16'h9C00}
    };

    // Open drain wire: an unknown enable counts as released.
    assign sda_w = sda_m & (sda_oe !== 1'b1);

    // System clock, 5 ns.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Link clock, 48 ns, offset 7 ns; every fifth link edge still lines up with clk_sys.
    initial begin
        clk_link = 1'b0;
        #7;
        forever #24 clk_link = ~clk_link;
    end

    eeprom_serial_word_access #(
        .FIFO_DEPTH (eeprom_pkg::FIFO_DEPTH),
        .PROG_CYCLES(PROG)
    ) uut (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clk_link (clk_link),
        .scl      (scl),
        .sda_i    (sda_w),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .prog_busy(prog_busy)
    );

    link_master m (
        .scl  (scl),
        .sda_m(sda_m),
        .sda  (sda_w)
    );

    task automatic finish_test();
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    // Bounded wait for the busy flag to reach a level.
    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (prog_busy !== v && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(16'(prog_busy), 16'(v));
    endtask

    // Write frame in the order that the low-first flag selects.
    task automatic wr(input case_t c);
        logic [15:0] w;
        m.start();
        m.send_byte({c.row, 1'b0, c.lo, 1'b0}, a);
        chk(16'(a), 16'h0000);
        w = c.lo ? c.data : {c.data[7:0], c.data[15:8]};
        m.send_byte(w[7:0], a);
        chk(16'(a), 16'h0000);
        if (c.two) begin
            m.send_byte(w[15:8], a);
            chk(16'(a), 16'h0000);
        end
        m.stop();
        mem[c.row] = c.two ? c.data : c.lo ? {mem[c.row][15:8], w[7:0]}
                                           : {w[7:0], mem[c.row][7:0]};
    endtask

    // Read n bytes from a row, each checked against the model memory.
    task automatic rd(input logic [4:0] row, input logic lo, input int n);
        logic [7:0] b;
        logic [7:0] e;
        logic [4:0] r;
        r = row;
        m.start();
        m.send_byte({row, ~lo, lo, 1'b1}, a);
        chk(16'(a), 16'h0000);
        for (int k = 0; k < n; k++) begin
            m.recv_byte(k < n - 1, b);
            e = (k[0] ^ lo) ? mem[r][7:0] : mem[r][15:8];
            chk(16'(b), 16'(e));
            if (k[0]) begin
                r = lo ? r + eeprom_pkg::ROW_ONE
                       : r - eeprom_pkg::ROW_ONE;
            end
        end
        m.stop();
    endtask

    // A hang ends the run as a failure.
    initial begin
        #560000;
        failures++;
        finish_test();
    end

    // Reset, table of write and read-back rows, then awkward cases.
    initial begin
        rst_n = 1'b0;
        failures = 0;
        comparisons = 0;
        repeat (6) @(posedge clk_link);
        @(posedge clk_sys);
        #1;
        chk(16'(sda_oe), 16'h0000);
        chk(16'(prog_busy), 16'h0000);
        rst_n = 1'b1;
        repeat (6) @(posedge clk_link);
        @(posedge clk_sys);
        #1;
        m.init_link(a);
        chk(16'(a), 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i]);
            wait_busy(1'b1, 200);
            wait_busy(1'b0, PROG + 500);
            rd(rows[i].row, rows[i].lo, 2);
        end
        // Polling while programming runs must go unanswered.
        wr(rows[2]);
        wait_busy(1'b1, 200);
        m.start();
        m.send_byte(8'h1B, a);
        chk(16'(a), 16'h0001);
        m.stop();
        wait_busy(1'b0, PROG + 500);
        rd(5'h1F, 1'b1, 4);
        rd(5'h00, 1'b0, 4);
        finish_test();
    end
endmodule
